// >>> core/phydbg_jabber.sv
`timescale 1ns/1ps
module phydbg_jabber #(
   parameter int WIDTH = phydbg_pkg::JAB_WIDTH
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             enable_i,
   input  wire logic             tx_active_i,
   output logic [WIDTH-1:0]      count_o
);
   import phydbg_pkg::*;
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   // -------------------------------------------------------------------------
   // counter
   // -------------------------------------------------------------------------
   always_comb begin
      next_count = count;
      if (!enable_i || !tx_active_i) begin
         next_count = '0;
      end else if (count != '1) begin
         next_count = count + WIDTH'(1);
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= '0;
      end else if (ce_i) begin
         count <= next_count;
      end
   end
   assign count_o = count;
endmodule

// >>> core/phydbg_pkg.sv
//
// Function
// - while auto crossover is on, the forced pair-select bit has no effect.
// - with crossover off, pair-select 1 gives MDI and 0 gives MDI-X.
// - auto crossover runs while crossover-disable is 0 (reset) and stops when it is 1.
// - coding-sublayer loopback bit lets the basic loopback bit act in 10/100 operation.
// - interrupt output is active high when the polarity bit is 1, active low when 0 (reset).
// - the jabber counter runs only while jabber-enable is 1, which is its reset value.
// - three read-only bits report resolved speed 1000, 100 and 10, all reset to 0.
// - a read-only bit reports duplex, 1 full and 0 half.
// - a read-only bit reports gigabit role, 1 master and 0 slave.
// - software reset bit 1 resets the logic but keeps register contents; 0 releases it.
package phydbg_pkg;
   // -------------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------------
   localparam logic [4:0]  ADDR_DEBUG      = 5'h1c;
   localparam logic [4:0]  ADDR_XCVR       = 5'h1f;
   localparam logic [4:0]  ADDR_BASIC_CTRL = 5'h00;
   // debug register fields
   localparam int          DBG_PAIR_SEL    = 7;
   localparam int          DBG_XOVER_OFF   = 6;
   localparam int          DBG_LOOPBACK    = 0;
   localparam logic [15:0] DBG_RESET       = 16'h0000;
   localparam logic [15:0] DBG_RW_MASK     = 16'hffff;
   // transceiver control/status fields
   localparam int          XC_INT_POL      = 14;
   localparam int          XC_JAB_EN       = 9;
   localparam int          XC_SPD_1000     = 6;
   localparam int          XC_SPD_100      = 5;
   localparam int          XC_SPD_10       = 4;
   localparam int          XC_DUPLEX       = 3;
   localparam int          XC_MASTER       = 2;
   localparam int          XC_SW_RESET     = 1;
   localparam int          XC_LINK_FAIL    = 0;
   localparam logic [15:0] XC_RESET        = 16'h0200;
   localparam logic [15:0] XC_RW_MASK      = 16'hf382;
   // basic control loopback bit
   localparam int          BC_LOOPBACK     = 14;
   localparam logic [15:0] BC_RESET        = 16'h0000;
   // speed encoding from the resolver
   localparam logic [1:0]  SPEED_NONE      = 2'h0;
   localparam logic [1:0]  SPEED_10        = 2'h1;
   localparam logic [1:0]  SPEED_100       = 2'h2;
   localparam logic [1:0]  SPEED_1000      = 2'h3;
   localparam int          JAB_WIDTH       = 16;
endpackage

// >>> core/phydbg_regs.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module phydbg_regs #(
   parameter int JAB_WIDTH = phydbg_pkg::JAB_WIDTH
) (
   input  wire logic                 clk_i,
   input  wire logic                 reset_n_i,
   input  wire logic                 ce_i,
   input  wire logic [4:0]           addr_i,
   input  wire logic [15:0]          wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [15:0]          rdata_o,
   input  wire logic [1:0]           speed_i,
   input  wire logic                 duplex_i,
   input  wire logic                 master_i,
   input  wire logic                 link_fail_i,
   input  wire logic                 auto_swap_i,
   input  wire logic                 int_event_i,
   input  wire logic                 tx_active_i,
   output logic                      mdix_o,
   output logic                      loopback_10_100_o,
   output logic                      int_pin_o,
   output logic                      logic_reset_o,
   output logic [JAB_WIDTH-1:0]      jabber_count_o
);
   import phydbg_pkg::*;

   // -------------------------------------------------------------------------
   // synchronisers for pin-level status
   // -------------------------------------------------------------------------
   logic [6:0] sync_a;
   logic [6:0] sync_b;
   logic [6:0] next_sync_a;
   always_comb begin
      next_sync_a = {speed_i, duplex_i, master_i, link_fail_i, auto_swap_i, int_event_i};
   end
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         sync_a <= 7'h00;
         sync_b <= 7'h00;
      end else if (ce_i) begin
         sync_a <= next_sync_a;
         sync_b <= sync_a;
      end
   end
   logic [1:0] speed_s;
   logic       duplex_s;
   logic       master_s;
   logic       fail_s;
   logic       swap_s;
   logic       int_s;
   assign {speed_s, duplex_s, master_s, fail_s, swap_s, int_s} = sync_b;

   // -------------------------------------------------------------------------
   // register storage
   // -------------------------------------------------------------------------
   logic [15:0] dbg;
   logic [15:0] xc;
   logic [15:0] bc;
   logic [15:0] rdata;
   logic [2:0]  spd;
   logic [2:0]  stat;
   logic        mdix_q;
   logic        loop_q;
   logic        int_q;
   logic        swr_q;
   logic [15:0] next_dbg;
   logic [15:0] next_xc;
   logic [15:0] next_bc;
   logic [15:0] next_rdata;
   logic [2:0]  next_spd;
   logic [2:0]  next_stat;
   logic        next_loop;
   logic        next_int;
   logic        next_swr;
   logic        core_rst;

   function automatic logic [2:0] spd_decode(input logic [1:0] s);
      case (s)
         SPEED_1000: spd_decode = 3'h4;
         SPEED_100:  spd_decode = 3'h2;
         SPEED_10:   spd_decode = 3'h1;
         default:    spd_decode = 3'h0;
      endcase
   endfunction

   always_comb begin
      next_dbg = dbg;
      next_xc  = xc;
      next_bc  = bc;
      if (wr_i && addr_i == ADDR_DEBUG) begin
         next_dbg = wdata_i & DBG_RW_MASK;
      end
      if (wr_i && addr_i == ADDR_XCVR) begin
         next_xc = wdata_i & XC_RW_MASK;
      end
      if (wr_i && addr_i == ADDR_BASIC_CTRL) begin
         next_bc = wdata_i;
      end
      next_spd  = (fail_s || core_rst) ? 3'h0 : spd_decode(speed_s);
      next_stat = core_rst ? 3'h0 : {duplex_s, master_s, fail_s};
   end

   always_comb begin
      next_rdata = 16'h0000;
      if (rd_i) begin
         case (addr_i)
            ADDR_DEBUG:      next_rdata = dbg;
            ADDR_BASIC_CTRL: next_rdata = bc;
            ADDR_XCVR: begin
               next_rdata                 = xc;
               next_rdata[XC_SPD_1000]    = spd[2];
               next_rdata[XC_SPD_100]     = spd[1];
               next_rdata[XC_SPD_10]      = spd[0];
               next_rdata[XC_DUPLEX]      = stat[2];
               next_rdata[XC_MASTER]      = stat[1];
               next_rdata[XC_LINK_FAIL]   = stat[0];
            end
            default:         next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         dbg   <= DBG_RESET;
         xc    <= XC_RESET;
         bc    <= BC_RESET;
         rdata <= 16'h0000;
         spd   <= 3'h0;
         stat  <= 3'h0;
      end else if (ce_i) begin
         dbg   <= next_dbg;
         xc    <= next_xc;
         bc    <= next_bc;
         rdata <= next_rdata;
         spd   <= next_spd;
         stat  <= next_stat;
      end
   end

   // -------------------------------------------------------------------------
   // control outputs
   // -------------------------------------------------------------------------
   assign core_rst = xc[XC_SW_RESET];

   always_comb begin
      next_loop = dbg[DBG_LOOPBACK] && bc[BC_LOOPBACK] && !core_rst;
      next_int  = (int_s && !core_rst) ~^ xc[XC_INT_POL];
      next_swr  = core_rst;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         loop_q <= 1'b0;
         int_q  <= 1'b1;
         swr_q  <= 1'b0;
      end else if (ce_i) begin
         loop_q <= next_loop;
         int_q  <= next_int;
         swr_q  <= next_swr;
      end
   end

   logic sub_rst;
   assign sub_rst = !reset_n_i || core_rst;

   phydbg_xover u_xover (
      .clk_i       (clk_i),
      .rst_i       (sub_rst),
      .ce_i        (ce_i),
      .xover_off_i (dbg[DBG_XOVER_OFF]),
      .pair_sel_i  (dbg[DBG_PAIR_SEL]),
      .auto_swap_i (swap_s),
      .mdix_o      (mdix_q)
   );

   phydbg_jabber #(.WIDTH(JAB_WIDTH)) u_jabber (
      .clk_i       (clk_i),
      .rst_i       (sub_rst),
      .ce_i        (ce_i),
      .enable_i    (xc[XC_JAB_EN]),
      .tx_active_i (tx_active_i),
      .count_o     (jabber_count_o)
   );

   assign rdata_o           = rdata;
   assign mdix_o            = mdix_q;
   assign loopback_10_100_o = loop_q;
   assign int_pin_o         = int_q;
   assign logic_reset_o     = swr_q;

   // -------------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------------
   property p_forced_pair;
      @(posedge clk_i) disable iff (!reset_n_i)
      ce_i && !core_rst && dbg[DBG_XOVER_OFF] |=> mdix_o == !$past(dbg[DBG_PAIR_SEL]);
   endproperty
   a_forced_pair: assert property (p_forced_pair) else $error("forced pair wrong");

   property p_auto_pair;
      @(posedge clk_i) disable iff (!reset_n_i)
      ce_i && !core_rst && !dbg[DBG_XOVER_OFF] |=> mdix_o == $past(swap_s);
   endproperty
   a_auto_pair: assert property (p_auto_pair) else $error("auto pair wrong");

   property p_xover_reset;
      @(posedge clk_i) $rose(reset_n_i) |-> !dbg[DBG_XOVER_OFF];
   endproperty
   a_xover_reset: assert property (p_xover_reset) else $error("crossover off at reset");

   property p_loop;
      @(posedge clk_i) disable iff (!reset_n_i)
      ce_i && !core_rst |=> loopback_10_100_o ==
         ($past(dbg[DBG_LOOPBACK]) && $past(bc[BC_LOOPBACK]));
   endproperty
   a_loop: assert property (p_loop) else $error("loopback wrong");

   property p_int_pol;
      @(posedge clk_i) disable iff (!reset_n_i)
      ce_i && !core_rst |=> int_pin_o == ($past(int_s) ~^ $past(xc[XC_INT_POL]));
   endproperty
   a_int_pol: assert property (p_int_pol) else $error("interrupt level wrong");

   property p_jab_off;
      @(posedge clk_i) disable iff (!reset_n_i)
      ce_i && !xc[XC_JAB_EN] |=> jabber_count_o == '0;
   endproperty
   a_jab_off: assert property (p_jab_off) else $error("jabber counts while off");

   property p_spd_onehot;
      @(posedge clk_i) disable iff (!reset_n_i)
      $onehot0(spd);
   endproperty
   a_spd_onehot: assert property (p_spd_onehot) else $error("speed bits wrong");

   property p_spd_none;
      @(posedge clk_i) disable iff (!reset_n_i)
      ce_i && speed_s == SPEED_NONE |=> spd == 3'h0;
   endproperty
   a_spd_none: assert property (p_spd_none) else $error("speed bits set while unresolved");

   property p_swr_keep;
      @(posedge clk_i) disable iff (!reset_n_i)
      core_rst && !(wr_i && addr_i == ADDR_DEBUG) |=> $stable(dbg);
   endproperty
   a_swr_keep: assert property (p_swr_keep) else $error("soft reset lost registers");
endmodule

// >>> core/phydbg_xover.sv
`timescale 1ns/1ps
module phydbg_xover (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic xover_off_i,
   input  wire logic pair_sel_i,
   input  wire logic auto_swap_i,
   output logic      mdix_o
);
   import phydbg_pkg::*;
   logic mdix;
   logic next_mdix;
   // -------------------------------------------------------------------------
   // pair assignment
   // -------------------------------------------------------------------------
   always_comb begin
      if (xover_off_i) begin
         next_mdix = !pair_sel_i;
      end else begin
         next_mdix = auto_swap_i;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mdix <= 1'b0;
      end else if (ce_i) begin
         mdix <= next_mdix;
      end
   end
   assign mdix_o = mdix;
endmodule

// >>> verification/phydbg_link_partner.sv
`timescale 1ns/1ps
module phydbg_link_partner (
   input  wire logic [1:0] lp_speed_i,
   input  wire logic       clk_i,
   input  wire logic       lp_full_i,
   input  wire logic       lp_master_i,
   input  wire logic       lp_fail_i,
   input  wire logic       lp_cross_i,
   input  wire logic       lp_send_i,
   output logic      [1:0] speed_o,
   output logic            duplex_o,
   output logic            master_o,
   output logic            link_fail_o,
   output logic            auto_swap_o,
   output logic            tx_active_o
);
   // -----------------------------
   // link resolved with far end
   // -----------------------------
   always_ff @(posedge clk_i) begin
      speed_o     <= lp_speed_i;
      duplex_o    <= lp_full_i;
      master_o    <= ~lp_master_i;
      link_fail_o <= lp_fail_i;
      auto_swap_o <= lp_cross_i;
      tx_active_o <= lp_send_i;
   end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import phydbg_pkg::*;
   logic        clk_i       = 1'b0;
   logic        reset_n_i   = 1'b0;
   logic        ce_i        = 1'b1;
   logic [4:0]  addr_i      = 5'h00;
   logic [15:0] wdata_i     = 16'h0000;
   logic        wr_i        = 1'b0;
   logic        rd_i        = 1'b0;
   logic        int_event_i = 1'b0;
   logic [6:0]  lp          = 7'h00;
   logic [15:0] rdata_o;
   logic [15:0] jab;
   logic [1:0]  spd;
   logic        dup;
   logic        mst;
   logic        lfail;
   logic        swp;
   logic        txa;
   logic        mdix;
   logic        lbk;
   logic        ipin;
   logic        lrst;
   int          errors      = 0;
   int          n_compared  = 0;

   phydbg_link_partner phydbg_link_partner_i (
      .clk_i(clk_i), .lp_speed_i(lp[6:5]), .lp_full_i(lp[4]), .lp_master_i(lp[3]),
      .lp_fail_i(lp[2]), .lp_cross_i(lp[1]), .lp_send_i(lp[0]), .speed_o(spd),
      .duplex_o(dup), .master_o(mst), .link_fail_o(lfail), .auto_swap_o(swp),
      .tx_active_o(txa));
   phydbg_regs phydbg_regs_i (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .speed_i(spd),
      .duplex_i(dup), .master_i(mst), .link_fail_i(lfail), .auto_swap_i(swp),
      .int_event_i(int_event_i), .tx_active_i(txa), .mdix_o(mdix),
      .loopback_10_100_o(lbk), .int_pin_o(ipin), .logic_reset_o(lrst),
      .jabber_count_o(jab));

   // -----------------------------
   // bus and compare tasks
   // -----------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bchk(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask
   task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask
   task automatic drive(input logic [6:0] v, input logic ev);
      @(posedge clk_i);
      lp          <= v;
      int_event_i <= ev;
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic end_of_test();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // -----------------------------
   // clock, watchdog, tests
   // -----------------------------
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      errors++;
      end_of_test();
   end
   initial begin
      logic [15:0] exp;
      logic [15:0] c0;
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rchk(ADDR_DEBUG, DBG_RESET);
      rchk(ADDR_XCVR, XC_RESET | 16'h0004);
      wr(5'h05, 16'hffff);
      rchk(5'h05, 16'h0000);
      drive(7'h02, 1'b0);
      wr(ADDR_DEBUG, 16'h0080);
      w(6);
      bchk(mdix, 1'b1);
      wr(ADDR_DEBUG, 16'h00c0);
      w(4);
      bchk(mdix, 1'b0);
      drive(7'h00, 1'b0);
      wr(ADDR_DEBUG, 16'h0040);
      w(6);
      bchk(mdix, 1'b1);
      wr(ADDR_DEBUG, 16'h0000);
      w(4);
      bchk(mdix, 1'b0);
      drive({SPEED_100, 5'h00}, 1'b1);
      wr(ADDR_BASIC_CTRL, 16'h4000);
      wr(ADDR_DEBUG, 16'h0001);
      w(6);
      bchk(lbk, 1'b1);
      bchk(ipin, 1'b0);
      rchk(ADDR_DEBUG, 16'h0001);
      wr(ADDR_DEBUG, 16'h0000);
      wr(ADDR_XCVR, 16'h4200);
      w(4);
      bchk(lbk, 1'b0);
      bchk(ipin, 1'b1);
      drive(7'h01, 1'b0);
      w(6);
      bchk(ipin, 1'b0);
      wr(ADDR_XCVR, XC_RESET);
      w(20);
      c0 = jab;
      w(5);
      chk(16'(jab > c0), 16'h0001);
      wr(ADDR_XCVR, 16'h0000);
      w(3);
      chk(jab, 16'h0000);
      w(10);
      chk(jab, 16'h0000);
      wr(ADDR_XCVR, XC_RESET);
      for (int i = 0; i < 4; i++) begin
         drive({2'(i), i[1], i[0], 3'h0}, 1'b0);
         w(6);
         exp = XC_RESET | {9'h000, i == 3, i == 2, i == 1, i[1], ~i[0], 2'h0};
         rchk(ADDR_XCVR, exp);
      end
      drive({SPEED_1000, 5'h14}, 1'b0);
      w(6);
      rchk(ADDR_XCVR, 16'h020d);
      drive({SPEED_100, 5'h10}, 1'b0);
      wr(ADDR_DEBUG, 16'h00c0);
      wr(ADDR_XCVR, 16'hffff);
      w(4);
      bchk(lrst, 1'b1);
      rchk(ADDR_XCVR, XC_RW_MASK);
      rchk(ADDR_DEBUG, 16'h00c0);
      wr(ADDR_XCVR, XC_RESET);
      w(6);
      bchk(lrst, 1'b0);
      rchk(ADDR_XCVR, 16'h022c);
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(ADDR_DEBUG, 16'h0001);
      @(posedge clk_i);
      ce_i <= 1'b1;
      rchk(ADDR_DEBUG, 16'h00c0);
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rchk(ADDR_DEBUG, DBG_RESET);
      rchk(ADDR_XCVR, 16'h022c);
      end_of_test();
   end
endmodule
